// [flts_top.sv]
/*
 * Sixteen-word table that is read either oldest-first or newest-first,
 * with its coils, operand and results behind a classic Wishbone slave.
 * Assumes one clock, synchronous active-high reset and one command at a time.
 */
`timescale 1ns/1ps

module flts_top (
    input  wire logic                              clk_i,
    input  wire logic                              rst_i,
    input  wire logic                              wb_cyc_i,
    input  wire logic                              wb_stb_i,
    input  wire logic                              wb_we_i,
    input  wire logic [flts_pkg::ADR_W-1:0]        wb_adr_i,
    input  wire logic [3:0]                        wb_sel_i,
    input  wire logic [31:0]                       wb_dat_i,
    output logic      [31:0]                       wb_dat_o,
    output logic                                   wb_ack_o,
    output flts_pkg::flts_word_t                   word_out_o,
    output logic      [flts_pkg::CNT_W-1:0]        entry_count_o,
    output logic                                   empty_flag_o,
    output logic                                   full_flag_o,
    output logic                                   irq_o
);

    // ***************************************************************
    // State
    // ***************************************************************
    typedef struct packed {
        flts_pkg::flts_bus_state_t             bus;
        logic [31:0]                           rdata;
        logic [flts_pkg::COILS_W-1:0]          coils;
        flts_pkg::flts_word_t                  word_in;
        flts_pkg::flts_word_t                  word_out;
        logic [flts_pkg::PTR_W-1:0]            head;
        logic [flts_pkg::CNT_W-1:0]            count;
        logic                                  pend;
        logic [flts_pkg::EV_W-1:0]             irq_stat;
        logic [flts_pkg::EV_W-1:0]             irq_mask;
    } flts_state_t;

    flts_state_t                   s_q;
    flts_state_t                   s_d;
    flts_pkg::flts_cmd_t           rise;
    logic [3:0]                    rise_vec;
    logic                          enable;
    logic                          clr_go;
    logic                          wr_go;
    logic                          wr_ok;
    logic                          rdo_go;
    logic                          rdn_go;
    logic                          rd_ok;
    logic                          is_empty;
    logic                          is_full;
    logic [flts_pkg::PTR_W-1:0]    waddr;
    logic [flts_pkg::PTR_W-1:0]    raddr;
    logic [flts_pkg::WORD_W-1:0]   mem_rdata;
    logic [flts_pkg::EV_W-1:0]     events;

    // Byte-lane merge shared by every writable register.
    function automatic logic [31:0] sel_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    // ***************************************************************
    // Command edges and table decisions
    // ***************************************************************
    flts_edge #(
        .W (4)
    ) u_edge (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .level_i (s_q.coils[flts_pkg::COILS_W-1:1]),
        .rise_o  (rise_vec)
    );

    assign rise     = flts_pkg::flts_cmd_t'(rise_vec);
    assign enable   = s_q.coils[flts_pkg::COIL_EN];
    assign is_empty = (s_q.count == '0);
    assign is_full  = (s_q.count == flts_pkg::FULL_COUNT);
    assign clr_go   = enable & rise.clr;
    assign wr_go    = enable & rise.wr & ~clr_go;
    assign wr_ok    = wr_go & ~is_full;
    assign rdo_go   = enable & rise.rd_old & ~clr_go & ~wr_go;
    assign rdn_go   = enable & rise.rd_new & ~clr_go & ~wr_go & ~rdo_go;
    assign rd_ok    = (rdo_go | rdn_go) & ~is_empty;

    // Entries live in a ring from head; newest sits at head + count - 1.
    assign waddr = s_q.head + s_q.count[flts_pkg::PTR_W-1:0];
    assign raddr = rdo_go ? s_q.head
                          : s_q.head + s_q.count[flts_pkg::PTR_W-1:0] - flts_pkg::PTR_ONE;

    flts_mem #(
        .W     (flts_pkg::WORD_W),
        .DEPTH (flts_pkg::TABLE_DEPTH),
        .AW    (flts_pkg::PTR_W)
    ) u_mem (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (wr_ok),
        .waddr_i (waddr),
        .wdata_i (s_q.word_in),
        .raddr_i (raddr),
        .rdata_o (mem_rdata)
    );

    always_comb begin
        events                          = '0;
        events[flts_pkg::EV_WR_DONE]    = wr_ok;
        events[flts_pkg::EV_RD_DONE]    = rd_ok;
        events[flts_pkg::EV_WR_REFUSE]  = wr_go & is_full;
        events[flts_pkg::EV_RD_REFUSE]  = (rdo_go | rdn_go) & is_empty;
    end

    // ***************************************************************
    // Next state
    // ***************************************************************
    always_comb begin
        logic [flts_pkg::EV_W-1:0] w1c;
        logic [31:0]               merged;
        s_d    = s_q;
        w1c    = '0;
        merged = '0;

        // Bus slave: answer one cycle after the request, then go straight back to idle.
        case (s_q.bus)
            flts_pkg::FLTS_BUS_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    s_d.bus   = flts_pkg::FLTS_BUS_ACK;
                    s_d.rdata = '0;
                    if (wb_adr_i == flts_pkg::ADR_COILS) begin
                        s_d.rdata[flts_pkg::COILS_W-1:0] = s_q.coils;
                        merged = sel_merge(32'(s_q.coils), wb_dat_i, wb_sel_i);
                        if (wb_we_i) begin
                            s_d.coils = merged[flts_pkg::COILS_W-1:0];
                        end
                    end else if (wb_adr_i == flts_pkg::ADR_WORD_IN) begin
                        s_d.rdata = s_q.word_in;
                        if (wb_we_i) begin
                            s_d.word_in = sel_merge(s_q.word_in, wb_dat_i, wb_sel_i);
                        end
                    end else if (wb_adr_i == flts_pkg::ADR_WORD_OUT) begin
                        s_d.rdata = s_q.word_out;
                    end else if (wb_adr_i == flts_pkg::ADR_STATUS) begin
                        s_d.rdata[flts_pkg::CNT_W-1:0]    = s_q.count;
                        s_d.rdata[flts_pkg::ST_EMPTY_BIT] = is_empty;
                        s_d.rdata[flts_pkg::ST_FULL_BIT]  = is_full;
                    end else if (wb_adr_i == flts_pkg::ADR_IRQ_STAT) begin
                        s_d.rdata[flts_pkg::EV_W-1:0] = s_q.irq_stat;
                        merged = sel_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
                        if (wb_we_i) begin
                            w1c = merged[flts_pkg::EV_W-1:0];
                        end
                    end else if (wb_adr_i == flts_pkg::ADR_IRQ_MASK) begin
                        s_d.rdata[flts_pkg::EV_W-1:0] = s_q.irq_mask;
                        merged = sel_merge(32'(s_q.irq_mask), wb_dat_i, wb_sel_i);
                        if (wb_we_i) begin
                            s_d.irq_mask = merged[flts_pkg::EV_W-1:0];
                        end
                    end else begin
                        s_d.rdata = '0;
                    end
                end
            end
            flts_pkg::FLTS_BUS_ACK: begin
                s_d.bus = flts_pkg::FLTS_BUS_IDLE;
            end
            default: begin
                s_d.bus = flts_pkg::FLTS_BUS_IDLE;
            end
        endcase

        // A pending read picks up the registered memory word one cycle later.
        if (s_q.pend) begin
            s_d.pend     = 1'b0;
            s_d.word_out = mem_rdata;
        end

        if (clr_go) begin
            s_d.count = '0;
            s_d.head  = '0;
        end else if (wr_ok) begin
            s_d.count    = s_q.count + 5'h01;
            s_d.word_out = s_q.word_in;
        end else if (rd_ok) begin
            s_d.count = s_q.count - 5'h01;
            s_d.pend  = 1'b1;
            if (rdo_go) begin
                s_d.head = s_q.head + flts_pkg::PTR_ONE;
            end
        end

        // A new event wins over a clear written in the same cycle.
        s_d.irq_stat = (s_q.irq_stat & ~w1c) | events;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q          <= '0;
            s_q.bus      <= flts_pkg::FLTS_BUS_IDLE;
            s_q.coils    <= flts_pkg::RST_COILS;
            s_q.word_in  <= flts_pkg::RST_WORD;
            s_q.word_out <= flts_pkg::RST_WORD;
            s_q.irq_stat <= flts_pkg::RST_EV;
            s_q.irq_mask <= flts_pkg::RST_EV;
        end else begin
            s_q <= s_d;
        end
    end

    // ***************************************************************
    // Outputs
    // ***************************************************************
    assign wb_dat_o      = s_q.rdata;
    assign wb_ack_o      = (s_q.bus == flts_pkg::FLTS_BUS_ACK);
    assign word_out_o    = s_q.word_out;
    assign entry_count_o = s_q.count;
    assign empty_flag_o  = is_empty;
    assign full_flag_o   = is_full;
    assign irq_o         = |(s_q.irq_stat & s_q.irq_mask);

    // ***************************************************************
    // Checks
    // ***************************************************************
    a_count_range: assert property (
        @(posedge clk_i) disable iff (rst_i) s_q.count <= flts_pkg::FULL_COUNT)
        else $error("entry count above sixteen");

    a_disabled_idle: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !enable |=> s_q.count == $past(s_q.count) && s_q.head == $past(s_q.head))
        else $error("table changed while disabled");

    a_write_count: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_ok |=> s_q.count == 5'($past(s_q.count) + 5'h01) && !empty_flag_o)
        else $error("write did not raise the count by one");

    a_write_echo: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_ok |=> word_out_o == $past(s_q.word_in))
        else $error("written word not shown on output");

    a_full_refuse: assert property (
        @(posedge clk_i) disable iff (rst_i)
        enable && rise.wr && !rise.clr && is_full |=> s_q.count == flts_pkg::FULL_COUNT
        && full_flag_o)
        else $error("write accepted on a full table");

    a_clear_empties: assert property (
        @(posedge clk_i) disable iff (rst_i)
        clr_go |=> s_q.count == '0 && empty_flag_o && !full_flag_o)
        else $error("clear did not empty the table");

    a_read_count: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_ok |=> s_q.count == 5'($past(s_q.count) - 5'h01) && !full_flag_o)
        else $error("read did not lower the count by one");

    a_empty_read: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (rdo_go || rdn_go) && is_empty |=> s_q.count == '0 ##1 $stable(word_out_o))
        else $error("read on empty table changed state");

    a_read_output: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_ok ##1 !wr_ok |=> word_out_o == $past(mem_rdata))
        else $error("read word not shown on output");

endmodule

// [flts_pkg.sv]
/*
 * Constants, register map and carrier types of the sixteen-word table stack.
 * Assumes a single 100 MHz clock with a synchronous active-high reset.
 */

package flts_pkg;

    // ***************************************************************
    // Table geometry
    // ***************************************************************
    localparam int             WORD_W      = 32;
    localparam int             TABLE_DEPTH = 16;
    localparam int             PTR_W       = 4;
    localparam int             CNT_W       = 5;
    localparam logic [CNT_W-1:0] FULL_COUNT = 5'h10;
    localparam logic [PTR_W-1:0] PTR_ONE    = 4'h1;

    // ***************************************************************
    // Register offsets (byte addresses)
    // ***************************************************************
    localparam int             ADR_W        = 8;
    localparam logic [ADR_W-1:0] ADR_COILS    = 8'h00;
    localparam logic [ADR_W-1:0] ADR_WORD_IN  = 8'h04;
    localparam logic [ADR_W-1:0] ADR_WORD_OUT = 8'h08;
    localparam logic [ADR_W-1:0] ADR_STATUS   = 8'h0c;
    localparam logic [ADR_W-1:0] ADR_IRQ_STAT = 8'h10;
    localparam logic [ADR_W-1:0] ADR_IRQ_MASK = 8'h14;

    // ***************************************************************
    // Field positions
    // ***************************************************************
    localparam int COILS_W      = 5;
    localparam int COIL_EN      = 0;
    localparam int ST_EMPTY_BIT = 8;
    localparam int ST_FULL_BIT  = 9;
    localparam int EV_W         = 4;
    localparam int EV_WR_DONE   = 0;
    localparam int EV_RD_DONE   = 1;
    localparam int EV_WR_REFUSE = 2;
    localparam int EV_RD_REFUSE = 3;

    // ***************************************************************
    // Reset values
    // ***************************************************************
    localparam logic [COILS_W-1:0] RST_COILS = 5'h00;
    localparam logic [EV_W-1:0]    RST_EV    = 4'h0;
    localparam logic [WORD_W-1:0]  RST_WORD  = 32'h0000_0000;

    // ***************************************************************
    // Types
    // ***************************************************************
    typedef logic signed [WORD_W-1:0] flts_word_t;

    typedef enum logic [0:0] {
        FLTS_BUS_IDLE = 1'b0,
        FLTS_BUS_ACK  = 1'b1
    } flts_bus_state_t;

    // Command coils in the order of coil register bits 4 down to 1.
    typedef struct packed {
        logic clr;
        logic rd_new;
        logic rd_old;
        logic wr;
    } flts_cmd_t;

endpackage

// [flts_edge.sv]
/*
 * Rising-edge detector for a group of command levels.
 * Assumes the levels are synchronous to clk_i; the pulse is combinational.
 */
`timescale 1ns/1ps

module flts_edge #(
    parameter int W = 4
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] level_i,
    output logic      [W-1:0] rise_o
);

    typedef struct packed {
        logic [W-1:0] prev;
    } flts_edge_state_t;

    flts_edge_state_t s_q;
    flts_edge_state_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.prev = level_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // A level held high fires once only, so each edge is taken once.
    assign rise_o = level_i & ~s_q.prev;

endmodule

// [flts_mem.sv]
/*
 * Small word memory with one write port and one registered read port.
 * Assumes write and read addresses are valid in the cycle they are given.
 */
`timescale 1ns/1ps

module flts_mem #(
    parameter int W     = 32,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [W-1:0]  wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [W-1:0]  rdata_o
);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] cells;
        logic [W-1:0]            rdata;
    } flts_mem_state_t;

    flts_mem_state_t s_q;
    flts_mem_state_t s_d;

    always_comb begin
        s_d       = s_q;
        s_d.rdata = s_q.cells[raddr_i];
        if (we_i) begin
            s_d.cells[waddr_i] = wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o = s_q.rdata;

endmodule

// [flts_ctl_model.sv]
/*
 * Model of the user control logic: a classic Wishbone master that reads and
 * writes registers and raises one command coil at a time.
 * Assumes the slave answers each request with a one-cycle ack.
 */
`timescale 1ns/1ps

module flts_ctl_model (
    input  wire logic                         clk_i,
    input  wire logic                         ack_i,
    input  wire logic [31:0]                  dat_i,
    output logic                              cyc_o,
    output logic                              stb_o,
    output logic                              we_o,
    output logic      [flts_pkg::ADR_W-1:0]   adr_o,
    output logic      [3:0]                   sel_o,
    output logic      [31:0]                  dat_o
);
    // ********
    // Bus cycles
    // ********
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'hf;
        dat_o = 32'h0;
    end

    // Released lines flip to the inverse so a late sample cannot match by luck.
    task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= wr;
        adr_o <= adr;
        dat_o <= wd;
        @(posedge clk_i);
        while (ack_i !== 1'b1) begin
            @(posedge clk_i);
        end
        rd = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o  <= ~wr;
        adr_o <= ~adr;
        dat_o <= ~wd;
    endtask

    // ********
    // Commands
    // ********
    // The coil is lowered first so that every call gives exactly one edge.
    task automatic pulse(input logic en, input int bit_n);
        logic [31:0] d;
        xfer(1'b1, flts_pkg::ADR_COILS, 32'(en), d);
        xfer(1'b1, flts_pkg::ADR_COILS, 32'(en) | (32'h1 << bit_n), d);
        repeat (3) @(posedge clk_i);
    endtask
endmodule

// [fifo_lifo_table_stack_bench.sv]
/*
 * Self-checking bench of the table stack: a row table of ordinary commands,
 * then disable, full, interrupt, register map and reset cases.
 * Assumes the control model in flts_ctl_model.sv drives the register bus.
 */
`timescale 1ns/1ps

module fifo_lifo_table_stack_bench;
    typedef struct packed {
        logic [2:0]  op;
        logic [31:0] w_in;
        logic [31:0] w_exp;
        logic [4:0]  c_exp;
    } flts_row_t;

    logic                 clk_i;
    logic                 rst_i;
    logic                 cyc;
    logic                 stb;
    logic                 we;
    logic [7:0]           adr;
    logic [3:0]           sel;
    logic [31:0]          dat_w;
    logic [31:0]          dat_r;
    logic                 ack;
    flts_pkg::flts_word_t word_out;
    logic [4:0]           count;
    logic                 empty;
    logic                 full;
    logic                 irq;
    int                   num_errors;
    int                   total_checks;
    flts_row_t            rows [9];
    logic [31:0]          rd;

    flts_top u_flts_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
        .wb_ack_o(ack), .word_out_o(word_out), .entry_count_o(count),
        .empty_flag_o(empty), .full_flag_o(full), .irq_o(irq));

    flts_ctl_model u_flts_ctl_model (.clk_i(clk_i), .ack_i(ack), .dat_i(dat_r),
        .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(dat_w));

    // ********
    // Checking
    // ********
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic outs(input logic [31:0] w, input logic [4:0] c);
        #1;
        chk("word_out", 32'(word_out), w);
        chk("entry_count", 32'(count), 32'(c));
        chk("empty_flag", 32'(empty), 32'(c == 5'h00));
        chk("full_flag", 32'(full), 32'(c == 5'h10));
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ********
    // Clock and watchdog
    // ********
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // The whole run needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        end_sim();
    end

    // ********
    // Tests
    // ********
    initial begin
        rst_i = 1'b1;
        num_errors = 0;
        total_checks = 0;
        rows = '{'{3'd1, 32'h8000_0000, 32'h8000_0000, 5'h01},
                 '{3'd1, 32'h7fff_ffff, 32'h7fff_ffff, 5'h02},
                 '{3'd1, 32'h0000_0005, 32'h0000_0005, 5'h03},
                 '{3'd2, 32'h0, 32'h8000_0000, 5'h02},
                 '{3'd3, 32'h0, 32'h0000_0005, 5'h01},
                 '{3'd3, 32'h0, 32'h7fff_ffff, 5'h00},
                 '{3'd2, 32'h0, 32'h7fff_ffff, 5'h00},
                 '{3'd1, 32'hffff_ffff, 32'hffff_ffff, 5'h01},
                 '{3'd4, 32'h0, 32'hffff_ffff, 5'h00}};
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        outs(32'h0, 5'h00);
        u_flts_ctl_model.xfer(1'b0, flts_pkg::ADR_IRQ_MASK, 32'h0, rd);
        chk("irq_mask", rd, 32'h0);
        $display("reset test done");
        foreach (rows[i]) begin
            if (rows[i].op == 3'd1) begin
                u_flts_ctl_model.xfer(1'b1, flts_pkg::ADR_WORD_IN, rows[i].w_in, rd);
            end
            u_flts_ctl_model.pulse(1'b1, int'(rows[i].op));
            outs(rows[i].w_exp, rows[i].c_exp);
        end
        $display("row test done");
        u_flts_ctl_model.xfer(1'b1, flts_pkg::ADR_WORD_IN, 32'h1234_5678, rd);
        u_flts_ctl_model.pulse(1'b0, 1);
        outs(32'hffff_ffff, 5'h00);
        u_flts_ctl_model.xfer(1'b1, flts_pkg::ADR_COILS, 32'h0, rd);
        u_flts_ctl_model.xfer(1'b1, flts_pkg::ADR_COILS, 32'h3, rd);
        repeat (3) @(posedge clk_i);
        outs(32'h1234_5678, 5'h01);
        u_flts_ctl_model.pulse(1'b1, 4);
        outs(32'h1234_5678, 5'h00);
        $display("enable test done");
        u_flts_ctl_model.xfer(1'b1, flts_pkg::ADR_IRQ_MASK, 32'h4, rd);
        for (int i = 0; i < 17; i++) begin
            u_flts_ctl_model.xfer(1'b1, flts_pkg::ADR_WORD_IN, 32'hffff_fff0 + 32'(i), rd);
            u_flts_ctl_model.pulse(1'b1, 1);
            if (i == 15) begin
                chk("irq_masked", 32'(irq), 32'h0);
            end
        end
        chk("count_full", 32'(count), 32'h10);
        chk("full_flag", 32'(full), 32'h1);
        chk("irq_refused", 32'(irq), 32'h1);
        u_flts_ctl_model.xfer(1'b0, flts_pkg::ADR_STATUS, 32'h0, rd);
        chk("status", rd, 32'h0000_0210);
        u_flts_ctl_model.xfer(1'b1, flts_pkg::ADR_IRQ_STAT, 32'h4, rd);
        repeat (2) @(posedge clk_i);
        #1;
        chk("irq_cleared", 32'(irq), 32'h0);
        u_flts_ctl_model.pulse(1'b1, 2);
        outs(32'hffff_fff0, 5'h0f);
        u_flts_ctl_model.pulse(1'b1, 3);
        outs(32'hffff_ffff, 5'h0e);
        $display("full test done");
        u_flts_ctl_model.xfer(1'b1, flts_pkg::ADR_WORD_OUT, 32'h0, rd);
        u_flts_ctl_model.xfer(1'b0, flts_pkg::ADR_WORD_OUT, 32'h0, rd);
        chk("word_out_reg", rd, 32'hffff_ffff);
        u_flts_ctl_model.xfer(1'b0, 8'h20, 32'h0, rd);
        chk("unmapped", rd, 32'h0);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        outs(32'h0, 5'h00);
        $display("register and reset test done");
        end_sim();
    end
endmodule
